/* File: rtl/fsx_top.sv */
// Serial port, trim memory, conversion timing and register slave.
`include "fsx_params.svh"
module fsx_top (
    // Clock and reset.
    input  wire logic        CLOCK_I,
    input  wire logic        ARST_N_I,
    // Blank state of the permanent trim memory (factory only).
    input  wire logic        OTP_BLANK_N_I,
    // Serial link from the host.
    input  wire logic        SELECT_N_I,
    input  wire logic        SHIFT_CLK_I,
    input  wire logic        HOST_TO_SENSOR_LINE_I,
    // Serial link to the host, three-state.
    output logic             SENSOR_TO_HOST_LINE_O,
    output logic             SENSOR_TO_HOST_LINE_OE_O,
    // Avalon-MM slave.
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O
);
    localparam int CONV_CYC = `FSX_CONV_CYC;
    localparam int CONV_SEEN = CONV_CYC + 1;

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic sel_n_m_ff;
    logic sel_n_s_ff;
    logic sel_n_d_ff;
    logic sck_m_ff;
    logic sck_s_ff;
    logic sck_d_ff;
    logic sdi_m_ff;
    logic sdi_s_ff;
    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;

    // Two stages per pin, a third for edges; all three pins share the
    // same delay so data lines up with its clock edge.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sel_n_m_ff <= 1'b1;
            sel_n_s_ff <= 1'b1;
            sel_n_d_ff <= 1'b1;
            sck_m_ff   <= 1'b0;
            sck_s_ff   <= 1'b0;
            sck_d_ff   <= 1'b0;
            sdi_m_ff   <= 1'b0;
            sdi_s_ff   <= 1'b0;
        end else begin
            sel_n_m_ff <= SELECT_N_I;
            sel_n_s_ff <= sel_n_m_ff;
            sel_n_d_ff <= sel_n_s_ff;
            sck_m_ff   <= SHIFT_CLK_I;
            sck_s_ff   <= sck_m_ff;
            sck_d_ff   <= sck_s_ff;
            sdi_m_ff   <= HOST_TO_SENSOR_LINE_I;
            sdi_s_ff   <= sdi_m_ff;
        end
    end

    assign sel_fall = fsx_pkg::fsx_fall(sel_n_s_ff, sel_n_d_ff);
    assign sel_rise = fsx_pkg::fsx_rise(sel_n_s_ff, sel_n_d_ff);
    assign sck_rise = fsx_pkg::fsx_rise(sck_s_ff, sck_d_ff);
    assign sck_fall = fsx_pkg::fsx_fall(sck_s_ff, sck_d_ff);

    //--------------------------------------------------------------
    // Command receiver
    //--------------------------------------------------------------
    logic        sel_ff;
    logic [15:0] cmd_ff;
    logic [4:0]  cnt_ff;
    logic        cmd_ok;
    logic        apply;

    // Selection window follows the synchronised select level.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sel_ff <= 1'b0;
        end else if (sel_fall) begin
            sel_ff <= 1'b1;
        end else if (sel_rise) begin
            sel_ff <= 1'b0;
        end
    end

    // Bits enter MSB first at rising shift edges inside the window.
    // The count saturates so an overlong frame never wraps to a legal size.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cmd_ff <= '0;
            cnt_ff <= '0;
        end else if (sel_fall) begin
            cnt_ff <= '0;
        end else if (sel_ff && sck_rise) begin
            cmd_ff <= {cmd_ff[14:0], sdi_s_ff};
            if (cnt_ff != 5'h1F) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    // A write is exactly 16 bits with the 10 prefix and zero padding;
    // a leading zero makes the frame a read and nothing is applied.
    assign cmd_ok = cnt_ff == 5'(`FSX_CMD_BITS) && cmd_ff[15:14] == 2'b10
                    && cmd_ff[4:1] == 4'h0;
    assign apply = sel_rise && sel_ff && cmd_ok;

    //--------------------------------------------------------------
    // Trim settings and permanent memory
    //--------------------------------------------------------------
    fsx_pkg::fsx_cfg_t active_ff;
    fsx_pkg::fsx_cfg_t stored_ff;
    fsx_pkg::fsx_cfg_t pend_cfg_ff;
    fsx_pkg::fsx_cfg_t cmd_cfg;
    logic              pend_ff;
    logic              boot_ff;

    // Filter code sits in bits 13:11, gain code in bits 10:5.
    assign cmd_cfg = fsx_pkg::fsx_cfg_t'(cmd_ff[13:5]);

    // Stored bits survive the block reset; only the blank input clears
    // them, standing in for unprogrammed cells.
    always_ff @(posedge CLOCK_I or negedge OTP_BLANK_N_I) begin
        if (!OTP_BLANK_N_I) begin
            stored_ff <= '0;
        end else if (ARST_N_I && sel_fall && pend_ff) begin
            stored_ff <= stored_ff | pend_cfg_ff;
        end
    end

    // A burn waits for the next frame start to strike the cells.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pend_ff     <= 1'b0;
            pend_cfg_ff <= '0;
        end else if (apply && cmd_ff[0]) begin
            pend_ff     <= 1'b1;
            pend_cfg_ff <= cmd_cfg;
        end else if (sel_fall) begin
            pend_ff <= 1'b0;
        end
    end

    // Settings clear at reset, then reload from the cells once.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            active_ff <= '0;
            boot_ff   <= 1'b0;
        end else if (!boot_ff) begin
            active_ff <= stored_ff;
            boot_ff   <= 1'b1;
        end else if (apply) begin
            active_ff <= cmd_cfg;
        end
    end

    //--------------------------------------------------------------
    // Conversion timing and filter
    //--------------------------------------------------------------
    fsx_pkg::fsx_cv_state_t cv_state_ff;
    logic [11:0] cv_cnt_ff;
    logic [11:0] raw_ff;
    logic [11:0] held_ff;
    logic        step_ff;
    logic [11:0] filt_result;

    // Sample held at select fall, converted a fixed time later.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cv_state_ff <= fsx_pkg::CV_IDLE;
            cv_cnt_ff   <= '0;
            held_ff     <= '0;
            step_ff     <= 1'b0;
        end else begin
            step_ff <= 1'b0;
            if (sel_fall) begin
                cv_state_ff <= fsx_pkg::CV_WAIT;
                cv_cnt_ff   <= '0;
                held_ff     <= raw_ff;
            end else begin
                unique case (cv_state_ff)
                    fsx_pkg::CV_IDLE: begin
                        cv_cnt_ff <= '0;
                    end
                    fsx_pkg::CV_WAIT: begin
                        cv_cnt_ff <= cv_cnt_ff + 12'h001;
                        if (cv_cnt_ff == 12'(CONV_CYC - 1)) begin
                            step_ff     <= 1'b1;
                            cv_state_ff <= fsx_pkg::CV_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    fsx_filter #(
        .W(12)
    ) u_filter (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .step_i   (step_ff),
        .sample_i (held_ff),
        .cfg_i    (active_ff),
        .result_o (filt_result)
    );

    //--------------------------------------------------------------
    // Output shifter
    //--------------------------------------------------------------
    logic [11:0] out_sh_ff;

    // Loaded at select fall with the last result, moved at falls.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            out_sh_ff <= '0;
        end else if (sel_fall) begin
            out_sh_ff <= filt_result;
        end else if (sel_ff && sck_fall) begin
            out_sh_ff <= {out_sh_ff[10:0], 1'b0};
        end
    end

    assign SENSOR_TO_HOST_LINE_O    = out_sh_ff[11];
    assign SENSOR_TO_HOST_LINE_OE_O = sel_ff;

    //--------------------------------------------------------------
    // Avalon-MM slave
    //--------------------------------------------------------------
    logic        ack_ff;
    logic        req;
    logic [31:0] rdata_ff;

    // One wait cycle per access keeps read data registered.
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req & ~ack_ff;
    assign AVS_READDATA_O = rdata_ff;

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (AVS_READ_I && !ack_ff) begin
                unique case (AVS_ADDRESS_I)
                    `FSX_OFS_RAW:    rdata_ff <= {20'h00000, raw_ff};
                    `FSX_OFS_STATUS: rdata_ff <= {21'h000000, sel_ff,
                                                  pend_ff, active_ff};
                    `FSX_OFS_STORED: rdata_ff <= {23'h000000, stored_ff};
                    `FSX_OFS_RESULT: rdata_ff <= {20'h00000, filt_result};
                    default:         rdata_ff <= '0;
                endcase
            end
        end
    end

    // Converter input word; mid scale stands for zero field.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            raw_ff <= `FSX_ZERO_CODE;
        end else if (AVS_WRITE_I && ack_ff
                     && AVS_ADDRESS_I == `FSX_OFS_RAW) begin
            if (AVS_BYTEENABLE_I[0]) begin
                raw_ff[7:0] <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_BYTEENABLE_I[1]) begin
                raw_ff[11:8] <= AVS_WRITEDATA_I[11:8];
            end
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    logic [12:0] since_ff;

    // Cycles since the last select fall, saturating.
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            since_ff <= '0;
        end else if (sel_fall) begin
            since_ff <= 13'h0001;
        end else if (since_ff != 13'h1FFF) begin
            since_ff <= since_ff + 13'h0001;
        end
    end

    AST_HIZ_DESEL: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_n_s_ff && sel_n_d_ff |-> !SENSOR_TO_HOST_LINE_OE_O)
        else $error("Output driven while deselected");
    AST_OUT_AT_FALL: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_ff && $past(sel_ff) && $changed(out_sh_ff) |-> $past(sck_fall))
        else $error("Output moved without a shift falling edge");
    AST_IGNORE_IDLE: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        !sel_ff && !$past(sel_ff) |-> $stable(cmd_ff) && $stable(cnt_ff))
        else $error("Receiver moved while deselected");
    AST_SAMPLE_RISE: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_ff && sck_rise && !sel_fall |=> cmd_ff[0] == $past(sdi_s_ff))
        else $error("Input bit not captured at rising edge");
    AST_STICKY: assert property (@(posedge CLOCK_I)
        disable iff (!ARST_N_I || !OTP_BLANK_N_I)
        ($past(stored_ff) & ~stored_ff) == 9'h000)
        else $error("Programmed bit returned to zero");
    AST_BURN_EDGE: assert property (@(posedge CLOCK_I)
        disable iff (!ARST_N_I || !OTP_BLANK_N_I)
        $changed(stored_ff) |-> $past(sel_fall) && $past(pend_ff))
        else $error("Programming outside the following frame start");
    AST_CONV_TIME: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        step_ff |-> since_ff == 13'(CONV_SEEN))
        else $error("Conversion not at the fixed delay");
    AST_LOAD_FALL: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_fall |=> out_sh_ff == $past(filt_result) ##1 SENSOR_TO_HOST_LINE_OE_O)
        else $error("Result not loaded at select fall");
    AST_PREVIEW: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        apply && boot_ff && !cmd_ff[0] |=> active_ff == $past(cmd_cfg)
        && !pend_ff)
        else $error("Preview write not applied");

    // Settings reload once per reset and refused frames leave them.
    AST_RELOAD: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        $rose(boot_ff) |-> active_ff == $past(stored_ff))
        else $error("Settings not reloaded from the cells");
    AST_REFUSE: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_rise && boot_ff && !cmd_ok |=> $stable(active_ff))
        else $error("Refused frame changed the settings");

    COV_READ: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        sel_fall ##[1:1000] sck_fall);
    COV_PREVIEW: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        apply && !cmd_ff[0]);
    COV_BURN: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        pend_ff && sel_fall);
    COV_STEP: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        step_ff && active_ff.filter_select != 3'h0);
    COV_RELOAD: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
        $rose(boot_ff) && stored_ff != 9'h000);
endmodule // fsx_top

/* File: rtl/fsx_params.svh */
// Constants of the flux sensor serial port, filter and trim block.
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef FSX_PARAMS_SVH
`define FSX_PARAMS_SVH
`define FSX_CLK_MHZ       25
`define FSX_CONV_US       96
`define FSX_CONV_CYC      (`FSX_CONV_US * `FSX_CLK_MHZ)
`define FSX_CMD_BITS      16
`define FSX_ZERO_CODE     12'h800
`define FSX_GAIN_BASE     8'h60
`define FSX_FRAC          7
`define FSX_OFS_RAW       4'h0
`define FSX_OFS_STATUS    4'h4
`define FSX_OFS_STORED    4'h8
`define FSX_OFS_RESULT    4'hC
`define FSX_ST_PEND_BIT   9
`define FSX_ST_SEL_BIT    10
`endif

/* File: rtl/fsx_pkg.sv */
// Types and helpers shared by the flux sensor block.
package fsx_pkg;
    // Filter code and gain code travel together.
    typedef struct packed {
        logic [2:0] filter_select;
        logic [5:0] gain_trim;
    } fsx_cfg_t;

    // Conversion timer states.
    typedef enum logic {CV_IDLE, CV_WAIT} fsx_cv_state_t;

    // Falling edge of a synchronised level.
    function automatic logic fsx_fall(input logic cur, input logic prev);
        return prev & ~cur;
    endfunction

    // Rising edge of a synchronised level.
    function automatic logic fsx_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction
endpackage : fsx_pkg

/* File: rtl/fsx_filter.sv */
// Gain trim and first-order averaging filter for one sample.
`include "fsx_params.svh"
module fsx_filter #(
    parameter int W = 12
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // One strobe per converted sample.
    input  wire logic             step_i,
    input  wire logic [W-1:0]     sample_i,
    input  wire fsx_pkg::fsx_cfg_t cfg_i,
    // Filtered result.
    output logic [W-1:0]          result_o
);
    localparam int AW = W + `FSX_FRAC;

    logic [AW-1:0]  acc_ff;
    logic [W-1:0]   gained;
    logic [AW:0]    diff;
    logic [AW:0]    nxt_acc;

    // Sensitivity is (96 + code) / 128 around mid scale, so each code
    // step is 1/128 and the span is about 0.75 to 1.24.
    always_comb begin
        logic signed [W:0]    dev;
        logic signed [W+9:0]  prod;
        logic signed [W+9:0]  sum;
        dev = $signed({1'b0, sample_i}) - $signed({1'b0, `FSX_ZERO_CODE});
        prod = dev * $signed({2'b00, `FSX_GAIN_BASE + {2'b00, cfg_i.gain_trim}});
        sum = (prod >>> `FSX_FRAC) + $signed({10'h000, `FSX_ZERO_CODE});
        if (sum < 0) begin
            gained = '0;
        end else if (sum > $signed({10'h000, {W{1'b1}}})) begin
            gained = {W{1'b1}};
        end else begin
            gained = sum[W-1:0];
        end
    end

    // Weight 2^-code: acc += (x - acc) >>> code, exact at code zero.
    assign diff = {1'b0, gained, {`FSX_FRAC{1'b0}}} - {1'b0, acc_ff};
    // Both terms are signed so a falling input shifts in copies of the sign.
    assign nxt_acc = $signed({1'b0, acc_ff})
                     + ($signed(diff) >>> cfg_i.filter_select);

    // The accumulator moves only per sample; a code change leaves it.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_ff <= '0;
        end else if (step_i) begin
            acc_ff <= nxt_acc[AW-1:0];
        end
    end

    assign result_o = acc_ff[AW-1:`FSX_FRAC];

    AST_FILT_PASS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        step_i && cfg_i.filter_select == 3'h0 |=> result_o == $past(gained))
        else $error("Unfiltered code did not pass the sample through");
    AST_FILT_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !step_i |=> $stable(acc_ff))
        else $error("Filter memory moved without a sample");
endmodule // fsx_filter

/* File: testbench/fsx_host_model.sv */
// Behavioural host master for the four-wire serial port of the sensor.
module fsx_host_model (
    // Clock.
    input  wire logic clk_i,
    // Lines driven toward the sensor.
    output logic      select_n_o,
    output logic      shift_clk_o,
    output logic      host_to_sensor_line_o,
    // Line driven by the sensor.
    input  wire logic sensor_to_host_line_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Four 40 ns clocks give half of the 320 ns shift clock period.
    localparam int HALF    = 4;
    // Select falls are kept 500 us apart so every conversion can land.
    localparam int MIN_GAP = 12500;

    int cyc     = 0;
    int fall_at = -MIN_GAP;

    // Only the host drives these lines; the clock rests low between frames.
    initial begin
        select_n_o            = 1'b1;
        shift_clk_o           = 1'b0;
        host_to_sensor_line_o = 1'b0;
    end

    // Cycle count used to space select falls.
    always @(posedge clk_i) cyc <= cyc + 1;

    // One frame: bits go out MSB first, data changes while the clock is low
    // and stays put across the rising edge. With sel low the select line is
    // left high, so the whole frame should be ignored by the sensor.
    task automatic xfer(input logic [16:0] bits, input int n, input logic sel,
                        output logic [11:0] rise_w, output logic [11:0] fall_w);
        rise_w = '0;
        fall_w = '0;
        while (sel && cyc - fall_at < MIN_GAP) @(posedge clk_i);
        @(posedge clk_i);
        if (sel) begin
            fall_at = cyc;
            select_n_o <= 1'b0;
        end
        repeat (2 * HALF) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            host_to_sensor_line_o <= bits[i];
            repeat (HALF) @(posedge clk_i);
            shift_clk_o <= 1'b1;
            if (n - 1 - i < 12) rise_w = {rise_w[10:0], sensor_to_host_line_i};
            repeat (HALF) @(posedge clk_i);
            if (n - 1 - i < 12) fall_w = {fall_w[10:0], sensor_to_host_line_i};
            shift_clk_o <= 1'b0;
        end
        repeat (HALF) @(posedge clk_i);
        select_n_o <= 1'b1;
        // A released input line must not keep showing the last bit.
        host_to_sensor_line_o <= ~host_to_sensor_line_o;
        repeat (2 * HALF) @(posedge clk_i);
    endtask
endmodule // fsx_host_model

/* File: testbench/fsx_tb_top.sv */
// Self-checking bench for the flux sensor serial, filter and trim block.
module flux_sensor_serial_filter_trim_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 100000;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        blank_n = 1'b0;
    logic        sel_n, sck, h2s, s2h, s2h_oe, av_wait;
    wire         s2h_w;
    logic [3:0]  av_a = 4'h0;
    logic [3:0]  av_be = 4'hF;
    logic        av_r = 1'b0;
    logic        av_w = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rd_d, d;
    logic [11:0] rw, fw;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;

    // No pull on the output wire, so an undriven line reads as Z.
    assign s2h_w = s2h_oe ? s2h : 1'bz;

    // 25 MHz system clock.
    initial forever #20 clk = ~clk;

    //--------------------------------------------------------------
    // Instances
    //--------------------------------------------------------------
    fsx_top dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .OTP_BLANK_N_I(blank_n),
        .SELECT_N_I(sel_n), .SHIFT_CLK_I(sck), .HOST_TO_SENSOR_LINE_I(h2s),
        .SENSOR_TO_HOST_LINE_O(s2h), .SENSOR_TO_HOST_LINE_OE_O(s2h_oe),
        .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r), .AVS_WRITE_I(av_w),
        .AVS_WRITEDATA_I(av_wd), .AVS_BYTEENABLE_I(av_be),
        .AVS_READDATA_O(av_rd_d), .AVS_WAITREQUEST_O(av_wait));

    fsx_host_model host (.clk_i(clk), .select_n_o(sel_n), .shift_clk_o(sck),
        .host_to_sensor_line_o(h2s), .sensor_to_host_line_i(s2h_w));

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Avalon access: request held until waitrequest is sampled low.
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, input logic [3:0] be);
        @(posedge clk);
        av_a  <= a;
        av_wd <= wd;
        av_be <= be;
        av_r  <= ~wr;
        av_w  <= wr;
        do @(posedge clk); while (av_wait !== 1'b0);
        d = av_rd_d;
        av_r <= 1'b0;
        av_w <= 1'b0;
    endtask

    task automatic reg_is(input logic [3:0] a, input logic [31:0] exp,
                          input string nm);
        av(1'b0, a, 32'h0, 4'hF);
        check(nm, d, exp);
    endtask

    function automatic logic [16:0] wcmd(input logic [2:0] f,
                                         input logic [5:0] g, input logic b);
        return {2'b10, f, g, 4'h0, b};
    endfunction

    function automatic logic [31:0] stat(input logic [2:0] f,
                                         input logic [5:0] g, input logic p);
        return {21'h0, 1'b0, p, f, g};
    endfunction

    task automatic frame(input logic [16:0] b, input int n);
        host.xfer(b, n, 1'b1, rw, fw);
    endtask

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    task automatic t_reset_regs();
        reg_is(4'h0, 32'h800, "raw");
        reg_is(4'h4, 32'h0, "status");
        reg_is(4'h8, 32'h0, "stored");
        reg_is(4'hC, 32'h0, "result");
        reg_is(4'h2, 32'h0, "unmapped");
        av(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
        reg_is(4'h4, 32'h0, "status_ro");
        check("oe_idle", {31'h0, s2h_oe}, 32'h0);
    endtask

    task automatic t_first_read();
        frame(17'h0, 12);
        check("first_read", {20'h0, rw}, 32'h0);
        check("edge_stable", {20'h0, fw}, 32'h0);
        check("oe_after", {31'h0, s2h_oe}, 32'h0);
        repeat (2400) @(posedge clk);
        reg_is(4'hC, 32'h800, "result_mid");
    endtask

    // Preview write after an identical frame sent while deselected.
    task automatic t_preview();
        av(1'b1, 4'h0, 32'h0000_0CFF, 4'h2);
        reg_is(4'h0, 32'hC00, "raw_be");
        host.xfer(wcmd(3'b001, 6'd32, 1'b0), 16, 1'b0, rw, fw);
        reg_is(4'h4, 32'h0, "deselected");
        frame(wcmd(3'b001, 6'd32, 1'b0), 16);
        reg_is(4'h4, stat(3'b001, 6'd32, 1'b0), "preview");
        reg_is(4'h8, 32'h0, "no_store");
        repeat (2400) @(posedge clk);
        reg_is(4'hC, 32'hA00, "half_weight");
    endtask

    task automatic t_filtered_read();
        frame(17'h0, 12);
        check("read_word", {20'h0, rw}, 32'hA00);
        check("edge_stable2", {20'h0, fw}, 32'hA00);
        repeat (2400) @(posedge clk);
        reg_is(4'hC, 32'hB00, "keeps_prev");
    endtask

    // Two burns; the second ORs into cells already set by the first.
    task automatic t_burn();
        frame(wcmd(3'b000, 6'b001100, 1'b1), 16);
        reg_is(4'h4, stat(3'b000, 6'b001100, 1'b1), "pend");
        reg_is(4'h8, 32'h0, "not_yet");
        repeat (2400) @(posedge clk);
        reg_is(4'hC, 32'hB60, "gain_trim");
        frame(17'h0, 17);
        check("timing_same", {20'h0, rw}, 32'hB60);
        reg_is(4'h8, 32'h00C, "stored1");
        reg_is(4'h4, stat(3'b000, 6'b001100, 1'b0), "clr");
        frame(wcmd(3'b011, 6'b000011, 1'b1), 16);
        frame(17'h0, 17);
        reg_is(4'h8, 32'h0CF, "stored2");
    endtask

    task automatic t_reload();
        arst_n <= 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_is(4'h4, stat(3'b011, 6'b001111, 1'b0), "reload");
        reg_is(4'h8, 32'h0CF, "cells_kept");
        reg_is(4'hC, 32'h0, "prev_zero");
        reg_is(4'h0, 32'h800, "raw_reset");
    endtask

    //--------------------------------------------------------------
    // Run control
    //--------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: seven spaced frames need about 75000 cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            summarize();
        end
    end

    // Reset with the trim cells blanked, then the scenarios in order.
    initial begin
        repeat (12) @(posedge clk);
        arst_n  <= 1'b1;
        blank_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_regs();
        t_first_read();
        t_preview();
        t_filtered_read();
        t_burn();
        t_reload();
        summarize();
    end
endmodule // flux_sensor_serial_filter_trim_tb_top
